// File: shared/erc_map.vh
// Purpose: Constants for the eight-bit RISC core: encodings, addresses, resets.
// Assumes: Included by every design file of the core by its bare name.
// Notes: Instruction encoding is local to this core.
//
// Function
// - Program and data memories have separate buses usable in the same cycle.
// - Next instruction word is fetched while the current one executes.
// - Thirty-two eight-bit working registers, each readable within one clock.
// - ALU reads two registers, computes and writes back in one clock.
// - Six registers pair up as three 16-bit data-space pointers.
// - One pointer pair also addresses constant tables in program flash.
// - ALU does register-register, register-immediate and single-register operations.
// - Status flags are updated after each arithmetic operation.
// - Instructions are one or two 16-bit words, most are one word.
// - With a boot section, self-write acts only when run from boot section.
// - Without a boot section, self-write may run from any flash location.
// - Calls and interrupts push the return address onto the SRAM stack.
// - Each interrupt has its own vector; lower vector address wins.
// - Global interrupt enable flag gates all interrupts.
// - Sixty-four I/O addresses, by I/O instructions or data space after registers.
// - Extended I/O is reached only by data-space load and store forms.
// - Flags are not saved on interrupt entry nor restored on return.
// - Vector entry is one word on small variants, two on large ones.
// - Interrupt entry clears global enable; interrupt return sets it again.
// - Sign flag equals negative flag xor overflow flag unless a store to the flags address writes it.
// - Stack grows down: data push minus one, return address minus two.
`ifndef ERC_MAP_VH
`define ERC_MAP_VH

// ****************************************************************
// Variant and reset values
// ****************************************************************
`define ERC_NIRQ 25
`define ERC_VEC_WORDS 2
`define ERC_HAS_BOOT 1
`define ERC_BOOT_START 14'h3000
`define ERC_STK_RST 16'h04ff
`define ERC_FLAGS_RST 8'h00
`define ERC_IR_RST 16'h0000

// ****************************************************************
// Data-space addresses and flag bits
// ****************************************************************
`define ERC_IO_BASE 16'h0020
`define ERC_ADDR_STK_LO 16'h005d
`define ERC_ADDR_STK_HI 16'h005e
`define ERC_ADDR_FLAGS 16'h005f
`define ERC_FB_GIE 7
`define ERC_FB_ZERO 1
`define ERC_FB_CARRY 0

// ****************************************************************
// Major opcodes, bits 15:12
// ****************************************************************
`define ERC_OP_ADD 4'h0
`define ERC_OP_SUB 4'h1
`define ERC_OP_AND 4'h2
`define ERC_OP_OR 4'h3
`define ERC_OP_XOR 4'h4
`define ERC_OP_MOV 4'h5
`define ERC_OP_ADDK 4'h6
`define ERC_OP_SUBK 4'h7
`define ERC_OP_ANDK 4'h8
`define ERC_OP_ORK 4'h9
`define ERC_OP_MOVK 4'ha
`define ERC_OP_ONE 4'hb
`define ERC_OP_MEM 4'hc
`define ERC_OP_IO 4'hd
`define ERC_OP_FLOW 4'he
`define ERC_OP_REL 4'hf

// ****************************************************************
// Sub-codes of memory and flow groups, bits 6:4 and 11:9
// ****************************************************************
`define ERC_M_LOAD 3'h0
`define ERC_M_STORE 3'h1
`define ERC_M_TABLE 3'h2
`define ERC_M_PUSH 3'h3
`define ERC_M_POP 3'h4
`define ERC_M_DLOAD 3'h5
`define ERC_M_DSTORE 3'h6
`define ERC_M_SELFW 3'h7
`define ERC_F_JUMP 3'h0
`define ERC_F_CALL 3'h1
`define ERC_F_RETS 3'h2
`define ERC_F_RETIRQ 3'h3
`define ERC_F_GIE_ON 3'h4
`define ERC_F_GIE_OFF 3'h5
`define ERC_F_BRZ 3'h6
`define ERC_F_BRNZ 3'h7

// ****************************************************************
// ALU operations
// ****************************************************************
`define ERC_A_ADD 4'h0
`define ERC_A_SUB 4'h1
`define ERC_A_AND 4'h2
`define ERC_A_OR 4'h3
`define ERC_A_XOR 4'h4
`define ERC_A_MOV 4'h5
`define ERC_A_INC 4'h6
`define ERC_A_DEC 4'h7
`define ERC_A_COM 4'h8
`define ERC_A_NEG 4'h9
`define ERC_A_LSR 4'ha
`define ERC_A_ROR 4'hb
`define ERC_A_SWAP 4'hc

`endif

// File: rtl/erc_alu.v
// Purpose: Single-cycle eight-bit ALU with flag generation.
// Assumes: Pure combinational; the core registers result and flags.
// Notes: Flags out are H S V N Z C, high bit first.
`timescale 1ns/1ps
`include "erc_map.vh"
module erc_alu (
  // Operands
  input wire [7:0] a_i,
  input wire [7:0] b_i,
  input wire [3:0] op_i,
  input wire c_i,
  // Result
  output reg [7:0] res_o,
  output wire [5:0] flg_o
);
  reg [8:0] sum;
  reg h;
  reg v;
  reg c;
  wire n;
  wire z;

  // ****************************************************************
  // Operation select
  // ****************************************************************
  always @* begin
    sum = 9'h000;
    h = 1'b0;
    v = 1'b0;
    c = c_i;
    res_o = a_i;
    case (op_i)
      `ERC_A_ADD: begin
        sum = {1'b0, a_i} + {1'b0, b_i};
        res_o = sum[7:0];
        c = sum[8];
        h = (a_i[3] & b_i[3]) | (b_i[3] & ~res_o[3]) | (~res_o[3] & a_i[3]);
        v = (a_i[7] & b_i[7] & ~res_o[7]) | (~a_i[7] & ~b_i[7] & res_o[7]);
      end
      `ERC_A_SUB: begin
        sum = {1'b0, a_i} - {1'b0, b_i};
        res_o = sum[7:0];
        c = sum[8];
        h = (~a_i[3] & b_i[3]) | (b_i[3] & res_o[3]) | (res_o[3] & ~a_i[3]);
        v = (a_i[7] & ~b_i[7] & ~res_o[7]) | (~a_i[7] & b_i[7] & res_o[7]);
      end
      `ERC_A_AND: res_o = a_i & b_i;
      `ERC_A_OR: res_o = a_i | b_i;
      `ERC_A_XOR: res_o = a_i ^ b_i;
      `ERC_A_MOV: res_o = b_i;
      `ERC_A_INC: begin
        res_o = a_i + 8'h01;
        v = (a_i == 8'h7f);
      end
      `ERC_A_DEC: begin
        res_o = a_i - 8'h01;
        v = (a_i == 8'h80);
      end
      `ERC_A_COM: begin
        res_o = ~a_i;
        c = 1'b1;
      end
      `ERC_A_NEG: begin
        res_o = 8'h00 - a_i;
        c = (res_o != 8'h00);
        v = (res_o == 8'h80);
        h = res_o[3] | a_i[3];
      end
      `ERC_A_LSR: begin
        res_o = {1'b0, a_i[7:1]};
        c = a_i[0];
        v = a_i[0];
      end
      `ERC_A_ROR: begin
        res_o = {c_i, a_i[7:1]};
        c = a_i[0];
        v = c_i ^ a_i[0];
      end
      `ERC_A_SWAP: res_o = {a_i[3:0], a_i[7:4]};
      default: res_o = a_i;
    endcase
  end

  assign n = res_o[7];
  assign z = (res_o == 8'h00);
  assign flg_o = {h, n ^ v, v, n, z, c};

endmodule // erc_alu

// File: rtl/erc_core.v
// Purpose: Eight-bit Harvard RISC core with one-stage prefetch pipeline.
// Assumes: Program and data memories read combinationally from the address outputs.
// Notes: Internal stack pointer and flags sit in the I/O window of data space.
`timescale 1ns/1ps
`include "erc_map.vh"
module erc_core #(
  parameter HAS_BOOT = `ERC_HAS_BOOT,
  parameter [13:0] BOOT_START = `ERC_BOOT_START,
  parameter VEC_WORDS = `ERC_VEC_WORDS
) (
  // Clock, reset, enable
  input wire clk_i,
  input wire rst_b_i,
  input wire ce_i,
  // Program memory
  output wire [13:0] prog_addr_o,
  input wire [15:0] prog_data_i,
  // Flash self-write strobe
  output wire self_wr_we_o,
  output wire [13:0] self_wr_addr_o,
  output wire [15:0] self_wr_data_o,
  // Data memory and I/O
  output wire [15:0] data_addr_o,
  output wire [7:0] data_wdata_o,
  output wire data_we_o,
  output wire data_re_o,
  input wire [7:0] data_rdata_i,
  // Interrupts
  input wire [`ERC_NIRQ-1:0] irq_i,
  output wire irq_ack_o,
  output wire [4:0] irq_id_o,
  // Status
  output wire [7:0] flags_register_o,
  output wire [15:0] stack_top_pointer_o
);

  // ****************************************************************
  // States and declarations
  // ****************************************************************
  localparam [6:0] S_RUN = 7'h01;
  localparam [6:0] S_EXEC2 = 7'h02;
  localparam [6:0] S_LOAD = 7'h04;
  localparam [6:0] S_PUSH2 = 7'h08;
  localparam [6:0] S_RET1 = 7'h10;
  localparam [6:0] S_RET2 = 7'h20;
  localparam [6:0] S_TABLE = 7'h40;
  localparam [13:0] VW = VEC_WORDS[13:0];

  reg [6:0] state_r;
  reg [13:0] instruction_counter_r;
  reg [13:0] ir_addr_r;
  reg [13:0] save_ic_r;
  reg [13:0] tgt_r;
  reg [15:0] ir_r;
  reg [15:0] w2_r;
  reg ir_ok_r;
  reg [7:0] rf [0:31];
  reg [7:0] flags_register_r;
  reg [15:0] stack_top_pointer_r;
  reg [5:0] ret_hi_r;
  reg [4:0] ld_rd_r;
  reg ld_int_r;
  reg [7:0] ld_val_r;
  reg [15:0] data_addr_r;
  reg [7:0] data_wdata_r;
  reg data_we_r;
  reg data_re_r;
  reg self_wr_we_r;
  reg [13:0] self_wr_addr_r;
  reg [15:0] self_wr_data_r;
  reg irq_ack_r;
  reg [4:0] irq_id_r;
  reg irq_hit;
  reg [4:0] irq_sel;
  reg [3:0] alu_op;
  integer i;
  integer j;

  // ****************************************************************
  // Decode
  // ****************************************************************
  wire [3:0] op = ir_r[15:12];
  wire [4:0] rd = ir_r[11:7];
  wire [4:0] rr = ir_r[6:2];
  wire [2:0] msub = ir_r[6:4];
  wire [1:0] psel = ir_r[3:2];
  wire [2:0] fsub = ir_r[11:9];
  wire is_imm = (op >= `ERC_OP_ADDK) && (op <= `ERC_OP_MOVK);
  wire [4:0] dst = is_imm ? {1'b1, ir_r[11:8]} : rd;
  wire alu_cls = (op <= `ERC_OP_ONE);
  wire flag_upd = alu_cls && (alu_op != `ERC_A_MOV) && (alu_op != `ERC_A_SWAP);
  wire two_word = ((op == `ERC_OP_MEM) &&
                   ((msub == `ERC_M_DLOAD) || (msub == `ERC_M_DSTORE))) ||
                  ((op == `ERC_OP_FLOW) &&
                   ((fsub == `ERC_F_JUMP) || (fsub == `ERC_F_CALL)));
  wire [15:0] ptr_x = {rf[27], rf[26]};
  wire [15:0] ptr_y = {rf[29], rf[28]};
  wire [15:0] ptr_z = {rf[31], rf[30]};
  wire [15:0] ptr_v = (psel == 2'd0) ? ptr_x : ((psel == 2'd1) ? ptr_y : ptr_z);
  wire [15:0] io_addr = `ERC_IO_BASE + {10'h000, ir_r[5:0]};
  wire zf = flags_register_r[`ERC_FB_ZERO];
  wire br_take = (fsub == `ERC_F_BRZ) ? zf : ~zf;
  wire [13:0] br_tgt = ir_addr_r + 14'h0001 + {{5{ir_r[8]}}, ir_r[8:0]};
  wire [13:0] rel_tgt = ir_addr_r + 14'h0001 + {{2{ir_r[11]}}, ir_r[11:0]};
  wire [13:0] vec_addr = ({9'h000, irq_sel} + 14'h0001) * VW;
  wire self_ok = (HAS_BOOT == 0) || (ir_addr_r >= BOOT_START);
  wire in_run = (state_r == S_RUN);
  wire take_irq = in_run && ir_ok_r && irq_hit &&
                  flags_register_r[`ERC_FB_GIE];
  wire exec = in_run && ir_ok_r && !take_irq;
  wire [15:0] stk_m1 = stack_top_pointer_r - 16'h0001;
  wire [15:0] stk_p1 = stack_top_pointer_r + 16'h0001;
  wire [7:0] alu_res;
  wire [5:0] alu_flg;

  // ****************************************************************
  // Interrupt priority and ALU select
  // ****************************************************************
  always @* begin
    irq_hit = 1'b0;
    irq_sel = 5'h00;
    for (j = `ERC_NIRQ - 1; j >= 0; j = j - 1) begin
      if (irq_i[j]) begin
        irq_hit = 1'b1;
        irq_sel = j[4:0];
      end
    end
  end

  always @* begin
    case (op)
      `ERC_OP_ADDK: alu_op = `ERC_A_ADD;
      `ERC_OP_SUBK: alu_op = `ERC_A_SUB;
      `ERC_OP_ANDK: alu_op = `ERC_A_AND;
      `ERC_OP_ORK: alu_op = `ERC_A_OR;
      `ERC_OP_MOVK: alu_op = `ERC_A_MOV;
      `ERC_OP_ONE: alu_op = {1'b0, msub} + `ERC_A_INC;
      default: alu_op = op;
    endcase
  end

  erc_alu u_alu (
    .a_i(rf[dst]),
    .b_i(is_imm ? ir_r[7:0] : rf[rr]),
    .op_i(alu_op),
    .c_i(flags_register_r[`ERC_FB_CARRY]),
    .res_o(alu_res),
    .flg_o(alu_flg)
  );

  // ****************************************************************
  // Helper tasks
  // ****************************************************************
  task fetch_next;
    begin
      ir_r <= prog_data_i;
      ir_addr_r <= instruction_counter_r;
      instruction_counter_r <= instruction_counter_r + 14'h0001;
      ir_ok_r <= 1'b1;
    end
  endtask

  task store_b;
    input [15:0] a;
    input [7:0] d;
    begin
      if (a == `ERC_ADDR_STK_LO) begin
        stack_top_pointer_r[7:0] <= d;
      end else if (a == `ERC_ADDR_STK_HI) begin
        stack_top_pointer_r[15:8] <= d;
      end else if (a == `ERC_ADDR_FLAGS) begin
        flags_register_r <= d;
      end else begin
        data_addr_r <= a;
        data_wdata_r <= d;
        data_we_r <= 1'b1;
      end
    end
  endtask

  task load_b;
    input [15:0] a;
    input [4:0] r;
    begin
      ld_rd_r <= r;
      data_addr_r <= a;
      ld_int_r <= 1'b1;
      if (a == `ERC_ADDR_STK_LO) begin
        ld_val_r <= stack_top_pointer_r[7:0];
      end else if (a == `ERC_ADDR_STK_HI) begin
        ld_val_r <= stack_top_pointer_r[15:8];
      end else if (a == `ERC_ADDR_FLAGS) begin
        ld_val_r <= flags_register_r;
      end else begin
        ld_int_r <= 1'b0;
        data_re_r <= 1'b1;
      end
      state_r <= S_LOAD;
    end
  endtask

  task push_ret;
    input [13:0] ra;
    input [13:0] tg;
    begin
      store_b(stack_top_pointer_r, ra[7:0]);
      stack_top_pointer_r <= stk_m1;
      ret_hi_r <= ra[13:8];
      tgt_r <= tg;
      ir_ok_r <= 1'b0;
      state_r <= S_PUSH2;
    end
  endtask

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      state_r <= S_RUN;
      instruction_counter_r <= 14'h0000;
      ir_addr_r <= 14'h0000;
      save_ic_r <= 14'h0000;
      tgt_r <= 14'h0000;
      ir_r <= `ERC_IR_RST;
      w2_r <= 16'h0000;
      ir_ok_r <= 1'b0;
      for (i = 0; i < 32; i = i + 1) begin
        rf[i] <= 8'h00;
      end
      flags_register_r <= `ERC_FLAGS_RST;
      stack_top_pointer_r <= `ERC_STK_RST;
      ret_hi_r <= 6'h00;
      ld_rd_r <= 5'h00;
      ld_int_r <= 1'b0;
      ld_val_r <= 8'h00;
      data_addr_r <= 16'h0000;
      data_wdata_r <= 8'h00;
      data_we_r <= 1'b0;
      data_re_r <= 1'b0;
      self_wr_we_r <= 1'b0;
      self_wr_addr_r <= 14'h0000;
      self_wr_data_r <= 16'h0000;
      irq_ack_r <= 1'b0;
      irq_id_r <= 5'h00;
    end else if (ce_i) begin
      data_we_r <= 1'b0;
      data_re_r <= 1'b0;
      self_wr_we_r <= 1'b0;
      irq_ack_r <= 1'b0;
      case (state_r)
        S_RUN: begin
          if (take_irq) begin
            flags_register_r[`ERC_FB_GIE] <= 1'b0;
            irq_ack_r <= 1'b1;
            irq_id_r <= irq_sel;
            push_ret(ir_addr_r, vec_addr);
          end else if (!exec) begin
            fetch_next;
          end else if (two_word) begin
            w2_r <= prog_data_i;
            instruction_counter_r <= instruction_counter_r + 14'h0001;
            state_r <= S_EXEC2;
          end else begin
            case (op)
              `ERC_OP_MEM: begin
                case (msub)
                  `ERC_M_LOAD: begin
                    load_b(ptr_v, rd);
                    fetch_next;
                  end
                  `ERC_M_STORE: begin
                    store_b(ptr_v, rf[rd]);
                    fetch_next;
                  end
                  `ERC_M_TABLE: begin
                    save_ic_r <= instruction_counter_r;
                    instruction_counter_r <= ptr_z[14:1];
                    ld_rd_r <= rd;
                    ir_ok_r <= 1'b0;
                    state_r <= S_TABLE;
                  end
                  `ERC_M_PUSH: begin
                    store_b(stack_top_pointer_r, rf[rd]);
                    stack_top_pointer_r <= stk_m1;
                    fetch_next;
                  end
                  `ERC_M_POP: begin
                    load_b(stk_p1, rd);
                    stack_top_pointer_r <= stk_p1;
                    fetch_next;
                  end
                  default: begin
                    if (self_ok) begin
                      self_wr_we_r <= 1'b1;
                      self_wr_addr_r <= ptr_z[14:1];
                      self_wr_data_r <= {rf[1], rf[0]};
                    end
                    fetch_next;
                  end
                endcase
              end
              `ERC_OP_IO: begin
                if (ir_r[6]) begin
                  store_b(io_addr, rf[rd]);
                end else begin
                  load_b(io_addr, rd);
                end
                fetch_next;
              end
              `ERC_OP_FLOW: begin
                case (fsub)
                  `ERC_F_RETS: begin
                    data_addr_r <= stk_p1;
                    data_re_r <= 1'b1;
                    stack_top_pointer_r <= stk_p1;
                    ir_ok_r <= 1'b0;
                    state_r <= S_RET1;
                  end
                  `ERC_F_RETIRQ: begin
                    flags_register_r[`ERC_FB_GIE] <= 1'b1;
                    data_addr_r <= stk_p1;
                    data_re_r <= 1'b1;
                    stack_top_pointer_r <= stk_p1;
                    ir_ok_r <= 1'b0;
                    state_r <= S_RET1;
                  end
                  `ERC_F_GIE_ON: begin
                    flags_register_r[`ERC_FB_GIE] <= 1'b1;
                    fetch_next;
                  end
                  `ERC_F_GIE_OFF: begin
                    flags_register_r[`ERC_FB_GIE] <= 1'b0;
                    fetch_next;
                  end
                  default: begin
                    if (br_take) begin
                      instruction_counter_r <= br_tgt;
                      ir_ok_r <= 1'b0;
                    end else begin
                      fetch_next;
                    end
                  end
                endcase
              end
              `ERC_OP_REL: begin
                instruction_counter_r <= rel_tgt;
                ir_ok_r <= 1'b0;
              end
              default: begin
                rf[dst] <= alu_res;
                if (flag_upd) begin
                  flags_register_r[5:0] <= alu_flg;
                end
                fetch_next;
              end
            endcase
          end
        end
        S_EXEC2: begin
          case ({op == `ERC_OP_FLOW, fsub == `ERC_F_CALL, msub == `ERC_M_DLOAD})
            3'b100, 3'b101: begin
              instruction_counter_r <= w2_r[13:0];
              ir_ok_r <= 1'b0;
              state_r <= S_RUN;
            end
            3'b110, 3'b111: begin
              push_ret(instruction_counter_r, w2_r[13:0]);
            end
            3'b001, 3'b011: begin
              load_b(w2_r, rd);
              fetch_next;
            end
            default: begin
              store_b(w2_r, rf[rd]);
              fetch_next;
              state_r <= S_RUN;
            end
          endcase
        end
        S_LOAD: begin
          rf[ld_rd_r] <= ld_int_r ? ld_val_r : data_rdata_i;
          state_r <= S_RUN;
        end
        S_PUSH2: begin
          store_b(stack_top_pointer_r, {2'b00, ret_hi_r});
          stack_top_pointer_r <= stk_m1;
          instruction_counter_r <= tgt_r;
          state_r <= S_RUN;
        end
        S_RET1: begin
          ret_hi_r <= data_rdata_i[5:0];
          data_addr_r <= stk_p1;
          data_re_r <= 1'b1;
          stack_top_pointer_r <= stk_p1;
          state_r <= S_RET2;
        end
        S_RET2: begin
          instruction_counter_r <= {ret_hi_r, data_rdata_i};
          state_r <= S_RUN;
        end
        S_TABLE: begin
          rf[ld_rd_r] <= ptr_z[0] ? prog_data_i[15:8] : prog_data_i[7:0];
          instruction_counter_r <= save_ic_r;
          state_r <= S_RUN;
        end
        default: begin
          state_r <= S_RUN;
        end
      endcase
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign prog_addr_o = instruction_counter_r;
  assign self_wr_we_o = self_wr_we_r;
  assign self_wr_addr_o = self_wr_addr_r;
  assign self_wr_data_o = self_wr_data_r;
  assign data_addr_o = data_addr_r;
  assign data_wdata_o = data_wdata_r;
  assign data_we_o = data_we_r;
  assign data_re_o = data_re_r;
  assign irq_ack_o = irq_ack_r;
  assign irq_id_o = irq_id_r;
  assign flags_register_o = flags_register_r;
  assign stack_top_pointer_o = stack_top_pointer_r;

endmodule // erc_core

// File: verif/erc_mem_model.sv
// Purpose: Program flash and data SRAM facing the core.
// Assumes: Both answer combinationally to the core's addresses.
// Notes: Idle read data shows the inverse of the last byte read.
`timescale 1ns/1ps
module erc_mem_model (
  // Clock
  input wire clk_i,
  input wire ce_i,
  // Program side
  input wire [13:0] prog_addr_i,
  output logic [15:0] prog_data_o,
  // Data side
  input wire [15:0] data_addr_i,
  input wire [7:0] data_wdata_i,
  input wire data_we_i,
  input wire data_re_i,
  output logic [7:0] data_rdata_o
);
  logic [15:0] pm [0:16383];
  logic [7:0] dm [0:65535];
  logic [7:0] last_r = 8'h00;
  assign prog_data_o = pm[prog_addr_i];
  assign data_rdata_o = data_re_i ? dm[data_addr_i] : ~last_r;
  always @(posedge clk_i) begin
    if (data_re_i)
      last_r <= dm[data_addr_i];
    if (data_we_i && ce_i)
      dm[data_addr_i] <= data_wdata_i;
  end
endmodule // erc_mem_model

// File: verif/erc_core_checker.sv
// Purpose: Port assertions for the core.
// Assumes: Bound to erc_core; one clock domain.
// Notes: Parameters follow the bound instance.
`timescale 1ns/1ps
`include "erc_map.vh"
module erc_core_checker #(
  parameter HAS_BOOT = 1,
  parameter [13:0] BOOT_START = 14'h3000,
  parameter VEC_WORDS = 2
) (
  // Clock and reset
  input wire clk_i,
  input wire rst_b_i,
  input wire ce_i,
  // Watched ports
  input wire [13:0] prog_addr_o,
  input wire [15:0] data_addr_o,
  input wire data_we_o,
  input wire self_wr_we_o,
  input wire [`ERC_NIRQ-1:0] irq_i,
  input wire irq_ack_o,
  input wire [4:0] irq_id_o,
  input wire [7:0] flags_register_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  function automatic [4:0] first_set(input [`ERC_NIRQ-1:0] v);
    first_set = 5'h0;
    for (int i = `ERC_NIRQ - 1; i >= 0; i--)
      if (v[i])
        first_set = 5'(i);
  endfunction
  sequence s_boot_fetch;
    prog_addr_o == 14'h0 ##1 prog_addr_o == 14'h1;
  endsequence
  sequence s_ret_push;
    data_we_o ##1 (data_we_o && data_addr_o == $past(data_addr_o) - 16'h1);
  endsequence
  chk_boot_fetch_seq: assert property ($rose(rst_b_i) && ce_i |-> s_boot_fetch)
    else $error("fetch order after reset");
  chk_sign_xor: assert property (flags_register_o[4] == (flags_register_o[3] ^ flags_register_o[2]))
    else $error("sign flag");
  chk_gie_gate: assert property (irq_ack_o |-> $past(flags_register_o[7]))
    else $error("interrupt taken while disabled");
  chk_irq_prio: assert property (irq_ack_o |-> irq_id_o == first_set($past(irq_i)))
    else $error("interrupt priority");
  chk_ret_push: assert property (irq_ack_o |-> s_ret_push)
    else $error("return address push");
  chk_vector_addr: assert property (irq_ack_o |-> ##1 prog_addr_o == 14'((irq_id_o + 5'h1) * VEC_WORDS))
    else $error("vector address");
  chk_gie_cleared: assert property (irq_ack_o |-> !flags_register_o[7])
    else $error("enable not cleared");
  chk_flags_kept: assert property (irq_ack_o |=> $stable(flags_register_o))
    else $error("flags touched on entry");
  chk_self_wr_boot: assert property (self_wr_we_o |-> HAS_BOOT == 0 || $past(prog_addr_o) - 14'h1 >= BOOT_START)
    else $error("self-write outside boot");
endmodule // erc_core_checker
bind erc_core erc_core_checker #(.HAS_BOOT(HAS_BOOT), .BOOT_START(BOOT_START),
  .VEC_WORDS(VEC_WORDS)) u_erc_core_checker (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
  .prog_addr_o(prog_addr_o), .data_addr_o(data_addr_o), .data_we_o(data_we_o),
  .self_wr_we_o(self_wr_we_o), .irq_i(irq_i), .irq_ack_o(irq_ack_o), .irq_id_o(irq_id_o),
  .flags_register_o(flags_register_o));

// File: verif/erc_core_test.sv
// Purpose: Self-checking bench for the core.
// Assumes: Memory model answers combinationally.
// Notes: Each scenario reloads memory and resets the core.
`timescale 1ns/1ps
module erc_core_test;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic ce_i = 1'b1;
  logic [24:0] irq_i = 25'h0;
  wire [13:0] pa, swa;
  wire [15:0] pd, da, swd, sp;
  wire [7:0] wd, rd, fl;
  wire [4:0] id;
  wire we, re, ack, sw;
  int error_cnt = 0;
  int n_checks = 0;
  int n_ack = 0;
  int n_sw = 0;
  erc_core u_erc_core (.clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i), .prog_addr_o(pa),
    .prog_data_i(pd), .self_wr_we_o(sw), .self_wr_addr_o(swa), .self_wr_data_o(swd),
    .data_addr_o(da), .data_wdata_o(wd), .data_we_o(we), .data_re_o(re), .data_rdata_i(rd),
    .irq_i(irq_i), .irq_ack_o(ack), .irq_id_o(id), .flags_register_o(fl),
    .stack_top_pointer_o(sp));
  erc_mem_model u_erc_mem_model (.clk_i(clk_i), .ce_i(ce_i), .prog_addr_i(pa), .prog_data_o(pd),
    .data_addr_i(da), .data_wdata_i(wd), .data_we_i(we), .data_re_i(re), .data_rdata_o(rd));
  initial forever #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    n_ack += (ack === 1'b1 && rst_b_i) ? 1 : 0;
    n_sw += (sw === 1'b1 && rst_b_i) ? 1 : 0;
  end
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task clear;
    rst_b_i = 1'b0;
    irq_i = 25'h0;
    for (int i = 0; i < 16384; i++) u_erc_mem_model.pm[i] = 16'hffff;
    for (int i = 0; i < 65536; i++) u_erc_mem_model.dm[i] = 8'h00;
  endtask
  task load(input logic [13:0] a, input logic [15:0] w[$]);
    foreach (w[i]) u_erc_mem_model.pm[a + 14'(i)] = w[i];
  endtask
  task boot(input int n);
    repeat (4) @(negedge clk_i);
    n_ack = 0;
    n_sw = 0;
    rst_b_i = 1'b1;
    repeat (n) @(negedge clk_i);
  endtask
  task t_alu;
    clear();
    load(14'h0, '{16'ha07f, 16'ha101, 16'h0844, 16'hc810});
    boot(12);
    chk("alu flags", 16'h002c, {8'h00, fl});
    chk("alu store", 16'h0080, {8'h00, u_erc_mem_model.dm[0]});
  endtask
  task t_call;
    clear();
    load(14'h0, '{16'ha0f0, 16'hd87d, 16'ha104, 16'hd8fe, 16'he200, 16'h0010});
    load(14'h10, '{16'he400, 16'hc810});
    u_erc_mem_model.dm[16'h04ef] = 8'haa;
    boot(30);
    chk("ret low", 16'h0006, {8'h00, u_erc_mem_model.dm[16'h04f0]});
    chk("ret high", 16'h0000, {8'h00, u_erc_mem_model.dm[16'h04ef]});
    chk("stack", 16'h04f0, sp);
    chk("discard", 16'h0000, {8'h00, u_erc_mem_model.dm[0]});
    chk("loop", 16'h0003, {3'h0, pa[13:1]});
  endtask
  task t_irq;
    clear();
    irq_i = 25'h28;
    load(14'h0, '{16'ha001, 16'ha155, 16'he800});
    boot(20);
    chk("acks", 16'h0001, 16'(n_ack));
    chk("irq id", 16'h0003, {11'h0, id});
    chk("irq flags", 16'h0000, {8'h00, fl});
    chk("vector", 16'h0004, {3'h0, pa[13:1]});
    chk("irq ret", 16'h0003, {8'h00, u_erc_mem_model.dm[16'h04ff]});
  endtask
  task t_self;
    clear();
    load(14'h0, '{16'hc070, 16'he000, 16'h3000});
    load(14'h3000, '{16'hae06, 16'ha0a5, 16'h5040, 16'hc070});
    boot(15);
    chk("self writes", 16'h0001, 16'(n_sw));
    chk("self addr", 16'h0003, {2'h0, swa});
    chk("self data", 16'h00a5, swd);
  endtask
  task t_stack;
    clear();
    load(14'h0, '{16'ha05a, 16'hc830, 16'hc8c0, 16'h715a, 16'hec01, 16'ha2ff, 16'hc910});
    u_erc_mem_model.dm[0] = 8'h33;
    boot(14);
    chk("sub flags", 16'h0002, {8'h00, fl});
    chk("push byte", 16'h005a, {8'h00, u_erc_mem_model.dm[16'h04ff]});
    chk("pop stack", 16'h04ff, sp);
    chk("branch skip", 16'h0000, {8'h00, u_erc_mem_model.dm[0]});
  endtask
  task tally_and_finish;
    if (error_cnt == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    t_alu();
    t_call();
    t_irq();
    t_self();
    t_stack();
    tally_and_finish();
  end
  initial begin
    #100000;
    error_cnt++;
    tally_and_finish();
  end
endmodule // erc_core_test
